// ---- verif/flow_partner.sv ----
`timescale 1ns/1ps
module flow_partner (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic fire,
   input wire logic [2:0] pin,
   input wire logic slow,
   output logic [5:0] rdy_in
);
   int hold_left;
   // external master: one ready pulse per request, short or long
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rdy_in <= 6'h00;
         hold_left <= 0;
      end else if (fire) begin
         rdy_in[pin] <= 1'b1;
         hold_left <= slow ? 3 : 1;
      end else if (hold_left > 1) begin
         hold_left <= hold_left - 1;
      end else begin
         rdy_in <= 6'h00;
         hold_left <= 0;
      end
   end
endmodule

// ---- verif/flow_strobe_ctl_tb_top.sv ----
`timescale 1ns/1ps
module flow_strobe_ctl_tb_top;
   import flow_pkg::*;
   logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
   logic [addr_w-1:0] paddr = '0;
   logic [31:0] pwdata = '0, prdata, rd;
   logic pready, pslverr, data_move, strobe_level, err, p;
   logic flow_state = 0, flow_logic_result = 0, fire = 0, slow = 0;
   logic [2:0] pin = 3'h0;
   logic [5:0] wf_ctl_level = 6'h00, wf_ctl_drive = 6'h00, rdy_in, ctl_o, ctl_oe_n;
   int bad_count = 0, checks_done = 0, moves = 0, base, e, n;

   always #2.5 pclk = ~pclk;
   // pulses counted mid-cycle, away from the launching edge
   always @(negedge pclk) if (data_move === 1'b1) moves++;

   flow_strobe_ctl u_flow_strobe_ctl (.pclk, .presetn, .paddr, .psel, .penable,
      .pwrite, .pwdata, .pready, .prdata, .pslverr, .flow_state, .flow_logic_result,
      .wf_ctl_level, .wf_ctl_drive, .rdy_in, .ctl_o, .ctl_oe_n, .data_move,
      .strobe_level);
   flow_partner u_flow_partner (.pclk, .presetn, .fire, .pin, .slow, .rdy_in);

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks_done++;
      if (got !== exp) begin
         bad_count++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   function automatic logic [31:0] pins();
      return {20'h00000, ctl_oe_n, ctl_o};
   endfunction

   task automatic cyc(input int k);
      repeat (k) @(posedge pclk);
   endtask

   task automatic apb(input logic w, input logic [addr_w-1:0] a, input logic [7:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= {24'h000000, d};
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1) begin
         @(posedge pclk);
      end
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic end_sim();
      $display("checks %0d mismatches %0d", checks_done, bad_count);
      if (bad_count == 0 && checks_done > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask

   initial begin
      #100000;
      bad_count++;
      end_sim();
   end

   initial begin
      cyc(8);
      presetn <= 1'b1;
      apb(1'b0, addr_stb, 8'h00);
      chk(rd, 32'h20);
      apb(1'b0, 18'h00000, 8'h00);
      chk({31'h0, err}, 32'h1);
      apb(1'b1, addr_stb, 8'hFF);
      apb(1'b0, addr_stb, 8'h00);
      chk(rd, 32'hF7);
      $display("test registers done");
      apb(1'b1, addr_stb, 8'h26);
      apb(1'b1, addr_eq0, 8'h2A);
      apb(1'b1, addr_eq1, 8'h15);
      apb(1'b1, addr_drive, 8'h03);
      wf_ctl_level <= 6'h3F;
      flow_state <= 1'b1;
      cyc(3);
      chk(pins(), 32'h0A8);
      apb(1'b0, addr_status, 8'h00);
      chk(rd, 32'h0A8);
      flow_logic_result <= 1'b1;
      cyc(3);
      chk(pins(), 32'h054);
      flow_logic_result <= 1'b0;
      apb(1'b1, addr_drive, 8'h80);
      apb(1'b1, addr_eq0, 8'h3A);
      cyc(3);
      chk({24'h0, ctl_oe_n, ctl_o[1:0]}, 32'hF2);
      flow_state <= 1'b0;
      $display("test patterns done");
      apb(1'b1, addr_drive, 8'h00);
      apb(1'b1, addr_eq0, 8'h00);
      apb(1'b1, addr_eq1, 8'h00);
      for (int t = 0; t < 2; t++) begin
         apb(1'b1, addr_stb, {2'b00, t[0], 5'h02});
         flow_logic_result <= t[0];
         flow_state <= 1'b1;
         e = moves;
         cyc(20);
         chk({31'h0, (moves - e) inside {[9:10]}}, 32'h1);
         flow_logic_result <= ~t[0];
         cyc(2);
         base = moves;
         cyc(10);
         chk(32'(moves - base), 32'h0);
         chk({31'h0, ctl_o[2]}, 32'((moves - e) % 2));
         chk({31'h0, strobe_level}, 32'((moves - e) % 2));
         if (t == 0) flow_state <= 1'b0;
         cyc(2);
      end
      p = 1'((moves - e) % 2);
      apb(1'b1, addr_stb, 8'h32);
      wf_ctl_level <= {6{~p}};
      wf_ctl_drive <= 6'h3F;
      flow_state <= 1'b0;
      cyc(3);
      chk({31'h0, ctl_o[2]}, {31'h0, p});
      apb(1'b1, addr_stb, 8'h22);
      cyc(3);
      chk({31'h0, ctl_o[2]}, {31'h0, ~p});
      $display("test master strobe done");
      for (int a = 0; a < 2; a++) begin
         apb(1'b1, addr_stb, {1'b1, a[0], 6'h04});
         flow_state <= 1'b1;
         base = moves;
         pin <= 3'h4;
         slow <= a[0];
         fire <= 1'b1;
         @(posedge pclk);
         fire <= 1'b0;
         n = 0;
         while (data_move !== 1'b1 && n < 10) begin
            @(posedge pclk);
            #1;
            n++;
         end
         chk(32'(n), 32'(2 + a));
         cyc(6);
         pin <= 3'h3;
         fire <= 1'b1;
         @(posedge pclk);
         fire <= 1'b0;
         cyc(8);
         chk(32'(moves - base), 32'h1);
         flow_state <= 1'b0;
      end
      $display("test slave strobe done");
      end_sim();
   end
endmodule

// ---- verilog/flow_pkg.sv ----
// Summary of operation
// - tristate mode off, in flow: all six control pins enabled except open-drain pins at level one; levels from active pattern.
// - tristate mode on: pattern 3:0 are levels, 7:4 enables, CMOS, pins 4-5 off.
// - tristate mode off: drive-type bit one gives open drain, zero gives CMOS.
// - in flow, waveform opcode ignored; pattern chosen by flow logic result.
// - role bit zero: master, strobe is the selected control pin.
// - role bit one: slave, strobe is the selected ready pin, driven externally.
// - slave role: async bit selects synchronous or asynchronous ready strobe.
// - master role: toggle-level bit picks result that toggles strobe; else freeze.
// - master exit: strobe pin returns to waveform opcodes unless hold bit set.
// - three-bit select field indexes one of six control or ready pins.
// - in flow, data moves only when the selected strobe directs.
package flow_pkg;
   localparam int num_ctl = 6;
   localparam int num_tri = 4;
   localparam int addr_w = 18;
   localparam int clk_period_ps = 5000;
   localparam int strobe_half_ns = 10;
   localparam int strobe_half_cycles =
      ((strobe_half_ns * 1000) + clk_period_ps - 1) / clk_period_ps;
   localparam int div_w = 4;
   localparam logic [div_w-1:0] div_last = div_w'(strobe_half_cycles - 1);
   localparam logic [15:0] idx_eq0 = 16'hE6C8;
   localparam logic [15:0] idx_eq1 = 16'hE6C9;
   localparam logic [15:0] idx_stb = 16'hE6CB;
   localparam logic [15:0] idx_drive = 16'hE6D0;
   localparam logic [15:0] idx_status = 16'hE6D1;
   localparam logic [addr_w-1:0] addr_eq0 = {idx_eq0, 2'b00};
   localparam logic [addr_w-1:0] addr_eq1 = {idx_eq1, 2'b00};
   localparam logic [addr_w-1:0] addr_stb = {idx_stb, 2'b00};
   localparam logic [addr_w-1:0] addr_drive = {idx_drive, 2'b00};
   localparam logic [addr_w-1:0] addr_status = {idx_status, 2'b00};
   localparam logic [7:0] stb_rst = 8'h20;
   localparam logic [7:0] pattern_rst = 8'h00;
   localparam logic [7:0] drive_rst = 8'h00;
   localparam logic [7:0] stb_wmask = 8'hF7;
   localparam int bit_role = 7;
   localparam int bit_async = 6;
   localparam int bit_toggle = 5;
   localparam int bit_strobe_hold_on_exit_bit = 4;
   localparam int bit_tristate = 7;
   localparam int sel_lsb = 0;
   localparam logic [2:0] sel_max = 3'h5;
   localparam logic [2:0] dec_none = 3'h0;
   localparam logic [2:0] dec_eq0 = 3'h1;
   localparam logic [2:0] dec_eq1 = 3'h2;
   localparam logic [2:0] dec_stb = 3'h3;
   localparam logic [2:0] dec_drive = 3'h4;
   localparam logic [2:0] dec_status = 3'h5;
   typedef enum logic [1:0] {st_idle, st_flow, st_strobe_hold_on_exit_bit} flow_st_t;
endpackage

// ---- verilog/flow_strobe_ctl.sv ----
// The APB interface to the registers is this design's own decision.
`timescale 1ns/1ps
module flow_strobe_ctl
   import flow_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic [flow_pkg::addr_w-1:0] paddr,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] pwdata,
   output logic pready,
   output logic [31:0] prdata,
   output logic pslverr,
   input wire logic flow_state,
   input wire logic flow_logic_result,
   input wire logic [flow_pkg::num_ctl-1:0] wf_ctl_level,
   input wire logic [flow_pkg::num_ctl-1:0] wf_ctl_drive,
   input wire logic [flow_pkg::num_ctl-1:0] rdy_in,
   output logic [flow_pkg::num_ctl-1:0] ctl_o,
   output logic [flow_pkg::num_ctl-1:0] ctl_oe_n,
   output logic data_move,
   output logic strobe_level
);
   import flow_pkg::*;

   function automatic logic [2:0] reg_decode(input logic [addr_w-1:0] a);
      logic [2:0] d;
      d = dec_none;
      case (a)
         addr_eq0: d = dec_eq0;
         addr_eq1: d = dec_eq1;
         addr_stb: d = dec_stb;
         addr_drive: d = dec_drive;
         addr_status: d = dec_status;
         default: d = dec_none;
      endcase
      return d;
   endfunction

   // register file and apb slave
   logic pready_r, pready_nxt;
   logic [31:0] prdata_r, prdata_nxt;
   logic pslverr_r, pslverr_nxt;
   logic [7:0] eq0_r, eq0_nxt;
   logic [7:0] eq1_r, eq1_nxt;
   logic [7:0] stb_r, stb_nxt;
   logic [7:0] drive_r, drive_nxt;
   logic [7:0] status_byte;
   logic [2:0] wr_dec, rd_dec;
   logic access, wr_en;

   // flow sequencing and strobe
   flow_st_t st_r, st_nxt;
   logic strobe_r, strobe_nxt;
   logic [div_w-1:0] cnt_r, cnt_nxt;
   logic move_r, move_nxt;
   logic prev_r, prev_nxt;
   logic [num_ctl-1:0] direct_r, direct_nxt;
   logic [num_ctl-1:0] rdy_sync;
   logic [num_ctl-1:0] ctl_r, ctl_nxt;
   logic [num_ctl-1:0] oen_r, oen_nxt;

   logic slave, async_mode, toggle_lvl, strobe_hold_on_exit_bit, tristate, sel_ok, sel_level, rise;
   logic [2:0] sel;
   logic [7:0] pattern;
   logic in_flow, master_active, toggling;

   assign slave = stb_r[bit_role];
   assign async_mode = stb_r[bit_async];
   assign toggle_lvl = stb_r[bit_toggle];
   assign strobe_hold_on_exit_bit = stb_r[bit_strobe_hold_on_exit_bit];
   assign sel = stb_r[sel_lsb +: 3];
   assign tristate = drive_r[bit_tristate];
   assign sel_ok = (sel <= sel_max);
   assign pattern = flow_logic_result ? eq1_r : eq0_r;
   assign in_flow = (st_r == st_flow);
   assign master_active = !slave && sel_ok && (st_r != st_idle);
   assign toggling = in_flow && !slave && sel_ok && (flow_logic_result == toggle_lvl);
   assign sel_level = sel_ok ? (async_mode ? rdy_sync[sel] : direct_r[sel]) : 1'b0;
   assign rise = sel_level && !prev_r;
   assign status_byte = {(st_r != st_idle), strobe_r, ctl_r};

   ready_sync u_sync (
      .pclk(pclk),
      .presetn(presetn),
      .d(rdy_in),
      .q(rdy_sync)
   );

   always_comb begin
      access = psel && penable && !pready_r;
      wr_en = psel && penable && pready_r && pwrite;
      wr_dec = reg_decode(paddr);
      rd_dec = reg_decode(paddr);
      pready_nxt = access;
      prdata_nxt = prdata_r;
      pslverr_nxt = 1'b0;
      eq0_nxt = eq0_r;
      eq1_nxt = eq1_r;
      stb_nxt = stb_r;
      drive_nxt = drive_r;
      if (access) begin
         pslverr_nxt = (rd_dec == dec_none);
         case (rd_dec)
            dec_eq0: prdata_nxt = {24'h000000, eq0_r};
            dec_eq1: prdata_nxt = {24'h000000, eq1_r};
            dec_stb: prdata_nxt = {24'h000000, stb_r};
            dec_drive: prdata_nxt = {24'h000000, drive_r};
            dec_status: prdata_nxt = {24'h000000, status_byte};
            default: prdata_nxt = 32'h00000000;
         endcase
      end
      if (wr_en) begin
         case (wr_dec)
            dec_eq0: eq0_nxt = pwdata[7:0];
            dec_eq1: eq1_nxt = pwdata[7:0];
            dec_stb: stb_nxt = pwdata[7:0] & stb_wmask;
            dec_drive: drive_nxt = pwdata[7:0];
            default: eq0_nxt = eq0_r;
         endcase
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready_r <= 1'b0;
         prdata_r <= 32'h00000000;
         pslverr_r <= 1'b0;
         eq0_r <= pattern_rst;
         eq1_r <= pattern_rst;
         stb_r <= stb_rst;
         drive_r <= drive_rst;
      end else begin
         pready_r <= pready_nxt;
         prdata_r <= prdata_nxt;
         pslverr_r <= pslverr_nxt;
         eq0_r <= eq0_nxt;
         eq1_r <= eq1_nxt;
         stb_r <= stb_nxt;
         drive_r <= drive_nxt;
      end
   end

   always_comb begin
      st_nxt = st_r;
      strobe_nxt = strobe_r;
      cnt_nxt = cnt_r;
      move_nxt = 1'b0;
      direct_nxt = rdy_in;
      prev_nxt = sel_level;
      case (st_r)
         st_idle: begin
            cnt_nxt = '0;
            if (flow_state) begin
               st_nxt = st_flow;
               strobe_nxt = sel_ok ? eq0_r[sel] : 1'b0;
            end
         end
         st_flow: begin
            if (!flow_state) begin
               st_nxt = (!slave && strobe_hold_on_exit_bit) ? st_strobe_hold_on_exit_bit : st_idle;
            end else if (toggling) begin
               if (cnt_r == div_last) begin
                  cnt_nxt = '0;
                  strobe_nxt = !strobe_r;
                  move_nxt = 1'b1;
               end else begin
                  cnt_nxt = cnt_r + 1'b1;
               end
            end else if (slave && sel_ok && rise) begin
               move_nxt = 1'b1;
            end
         end
         st_strobe_hold_on_exit_bit: begin
            if (flow_state) begin
               st_nxt = st_flow;
            end else if (!strobe_hold_on_exit_bit || slave) begin
               st_nxt = st_idle;
            end
         end
         default: st_nxt = st_idle;
      endcase
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st_r <= st_idle;
         strobe_r <= 1'b0;
         cnt_r <= '0;
         move_r <= 1'b0;
         prev_r <= 1'b0;
         direct_r <= '0;
      end else begin
         st_r <= st_nxt;
         strobe_r <= strobe_nxt;
         cnt_r <= cnt_nxt;
         move_r <= move_nxt;
         prev_r <= prev_nxt;
         direct_r <= direct_nxt;
      end
   end

   // per-pin level and enable
   generate
      for (genvar i = 0; i < num_ctl; i++) begin : g_pin
         logic lvl, want, od;
         always_comb begin
            lvl = in_flow ? pattern[i] : wf_ctl_level[i];
            if (master_active && (sel == 3'(i))) begin
               lvl = strobe_r;
            end
            if (tristate) begin
               want = (i < num_tri) ? (in_flow ? pattern[(i % num_tri) + num_tri]
                                               : wf_ctl_drive[i])
                                    : 1'b0;
               od = 1'b0;
            end else begin
               want = in_flow ? 1'b1 : wf_ctl_drive[i];
               od = drive_r[i];
            end
         end
         assign ctl_nxt[i] = lvl && !od;
         assign oen_nxt[i] = !(want && !(od && lvl));
      end
   endgenerate

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctl_r <= '0;
         oen_r <= '1;
      end else begin
         ctl_r <= ctl_nxt;
         oen_r <= oen_nxt;
      end
   end

   assign pready = pready_r;
   assign prdata = prdata_r;
   assign pslverr = pslverr_r;
   assign ctl_o = ctl_r;
   assign ctl_oe_n = oen_r;
   assign data_move = move_r;
   assign strobe_level = strobe_r;

   all_enabled_a: assert property (
      @(posedge pclk) disable iff (!presetn)
      (in_flow && !tristate && drive_r[5:0] == 6'h00) |=> (ctl_oe_n == 6'h00))
      else $error("control pins not all driven in flow");

   tri_upper_off_a: assert property (
      @(posedge pclk) disable iff (!presetn)
      (tristate && in_flow)
      |=> (ctl_oe_n[5:4] == 2'b11 && ctl_oe_n[3:0] == ~$past(pattern[7:4])))
      else $error("tristate mode pin enables wrong");

   open_drain_a: assert property (
      @(posedge pclk) disable iff (!presetn)
      (in_flow && !tristate && drive_r[1] && !(master_active && sel == 3'h1) && pattern[1])
      |=> (ctl_oe_n[1] && !ctl_o[1]))
      else $error("open drain pin not released");

   pattern_pick_a: assert property (
      @(posedge pclk) disable iff (!presetn)
      (in_flow && !master_active && !tristate && flow_logic_result)
      |=> (ctl_o == $past(eq1_r[5:0] & ~drive_r[5:0])))
      else $error("flow pattern one not driven");

   slave_edge_a: assert property (
      @(posedge pclk) disable iff (!presetn)
      (in_flow && flow_state && slave && sel_ok && rise) |=> data_move)
      else $error("ready strobe edge not acted on");

   sync_latency_a: assert property (
      @(posedge pclk) disable iff (!presetn)
      (in_flow && slave && !async_mode && sel_ok && $rose(rdy_in[sel]))
      ##1 (in_flow && flow_state && slave && !async_mode && $stable(sel)) |=> data_move)
      else $error("synchronous ready strobe latency wrong");

   async_latency_a: assert property (
      @(posedge pclk) disable iff (!presetn)
      (in_flow && slave && async_mode && sel_ok && $rose(rdy_in[sel])
      && !$past(rdy_in[sel], 2))
      ##1 (in_flow && slave && async_mode && $stable(sel)) |=> !data_move)
      else $error("asynchronous ready strobe bypassed synchroniser");

   async_move_a: assert property (
      @(posedge pclk) disable iff (!presetn)
      (in_flow && slave && async_mode && sel_ok && $rose(rdy_in[sel]))
      ##2 (in_flow && flow_state && slave && async_mode && $stable(sel)) |=> data_move)
      else $error("asynchronous ready strobe edge lost");

   freeze_a: assert property (
      @(posedge pclk) disable iff (!presetn)
      (in_flow && flow_state && !slave && flow_logic_result != toggle_lvl)
      |=> ($stable(strobe_r) && !data_move))
      else $error("master strobe moved while frozen");

   exit_a: assert property (
      @(posedge pclk) disable iff (!presetn)
      (in_flow && !flow_state && !slave && !strobe_hold_on_exit_bit) |=> (st_r == st_idle))
      else $error("master strobe kept after exit");

   bad_select_a: assert property (
      @(posedge pclk) disable iff (!presetn)
      (in_flow && !sel_ok) |=> !data_move)
      else $error("data moved with no strobe pin selected");
endmodule

// ---- verilog/ready_sync.sv ----
`timescale 1ns/1ps
module ready_sync
   import flow_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic [flow_pkg::num_ctl-1:0] d,
   output logic [flow_pkg::num_ctl-1:0] q
);
   logic [num_ctl-1:0] s1_r;
   logic [num_ctl-1:0] s2_r;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s1_r <= '0;
         s2_r <= '0;
      end else begin
         s1_r <= d;
         s2_r <= s1_r;
      end
   end

   assign q = s2_r;
endmodule
